//--- logic/hm_arith.sv
// combinational product and accumulate stage of the multiply-accumulate peripheral
// assumes operands and accumulator are registered by the instantiating module
`timescale 1ns/1ps
module hm_arith
    import hm_pkg::*;
#(
    parameter int W = 16
) (
    // operation
    input  wire mode_t          i_mode,
    input  wire logic [W-1:0]   i_a,
    input  wire logic [W-1:0]   i_b,
    input  wire logic [2*W-1:0] i_acc,
    // outcome
    output logic      [W-1:0]   o_lo,
    output logic      [W-1:0]   o_hi,
    output logic      [W-1:0]   o_ext
);

    logic        [2*W-1:0] prod_u;
    logic signed [2*W-1:0] prod_s;
    logic        [2*W:0]   sum;

    always_comb begin
        prod_u = {{W{1'b0}}, i_a} * {{W{1'b0}}, i_b};
        prod_s = $signed({{W{i_a[W-1]}}, i_a}) * $signed({{W{i_b[W-1]}}, i_b});
        sum    = '0;
        o_ext  = '0;
        unique case (i_mode)
            unsigned_multiply_mode: begin
                sum   = {1'b0, prod_u};
                o_ext = '0;
            end
            signed_multiply_mode: begin
                // sign sits in the top bit of the high word
                sum   = {prod_s[2*W-1], prod_s};
                o_ext = {W{prod_s[2*W-1]}};
            end
            unsigned_accumulate_mode: begin
                sum   = {1'b0, i_acc} + {1'b0, prod_u};
                o_ext = {{(W-1){1'b0}}, sum[2*W]};
            end
            signed_accumulate_mode: begin
                // 33-bit sum keeps the true sign even when 32 bits wrap
                sum   = {i_acc[2*W-1], i_acc} + {prod_s[2*W-1], prod_s};
                o_ext = {W{sum[2*W]}};
            end
        endcase
        o_lo = sum[W-1:0];
        o_hi = sum[2*W-1:W];
    end

endmodule // hm_arith

//--- logic/hm_params.svh
// offsets, reset values and field constants of the multiply-accumulate peripheral
// assumes a 16-bit word address bus with word registers on even addresses
`ifndef HM_PARAMS_SVH
`define HM_PARAMS_SVH

`define HM_OFS_UNS_MUL_A  16'h0130
`define HM_OFS_SGN_MUL_A  16'h0132
`define HM_OFS_UNS_ACC_A  16'h0134
`define HM_OFS_SGN_ACC_A  16'h0136
`define HM_OFS_OPERAND_B  16'h0138
`define HM_OFS_RESULT_LO  16'h013a
`define HM_OFS_RESULT_HI  16'h013c
`define HM_OFS_SUM_EXT    16'h013e

`define HM_RDATA_RST      16'h0000
`define HM_BYTE_W         8

`endif

//--- logic/hm_pkg.sv
// types shared by the multiply-accumulate peripheral
// assumes nothing beyond a SystemVerilog compiler
package hm_pkg;

    typedef enum logic [1:0] {
        unsigned_multiply_mode,
        signed_multiply_mode,
        unsigned_accumulate_mode,
        signed_accumulate_mode
    } mode_t;

    typedef enum logic [2:0] {
        sel_none,
        sel_first_operand,
        sel_second_operand,
        sel_result_low_word,
        sel_result_high_word,
        sel_sum_extension
    } reg_sel_t;

endpackage : hm_pkg

//--- logic/peripheral_multiply_accumulate.sv
// memory-mapped 16x16 multiply and multiply-accumulate peripheral
// assumes a single-cycle word bus from the cpu: one read or write strobe per cycle,
// byte writes land in the low byte with the high byte cleared
// the cpu never raises i_wr and i_rd in the same cycle
// results carry no reset value; software writes or computes them before use
`timescale 1ns/1ps
`include "hm_params.svh"
module peripheral_multiply_accumulate
    import hm_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    // peripheral bus
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic              i_byte,
    output logic      [DATA_W-1:0] o_rdata,
    // status
    output logic                   o_result_ready
);

    // register decode, shared by the write and read paths
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        reg_sel_t s;
        s = sel_none;
        unique case (addr)
            ADDR_W'(`HM_OFS_UNS_MUL_A),
            ADDR_W'(`HM_OFS_SGN_MUL_A),
            ADDR_W'(`HM_OFS_UNS_ACC_A),
            ADDR_W'(`HM_OFS_SGN_ACC_A): s = sel_first_operand;
            ADDR_W'(`HM_OFS_OPERAND_B): s = sel_second_operand;
            ADDR_W'(`HM_OFS_RESULT_LO): s = sel_result_low_word;
            ADDR_W'(`HM_OFS_RESULT_HI): s = sel_result_high_word;
            ADDR_W'(`HM_OFS_SUM_EXT):   s = sel_sum_extension;
            default:                    s = sel_none;
        endcase
        return s;
    endfunction

    // mode carried by the first-operand alias that was written
    function automatic mode_t alias_mode(input logic [ADDR_W-1:0] addr);
        mode_t m;
        m = unsigned_multiply_mode;
        if (addr == ADDR_W'(`HM_OFS_SGN_MUL_A)) begin
            m = signed_multiply_mode;
        end else if (addr == ADDR_W'(`HM_OFS_UNS_ACC_A)) begin
            m = unsigned_accumulate_mode;
        end else if (addr == ADDR_W'(`HM_OFS_SGN_ACC_A)) begin
            m = signed_accumulate_mode;
        end
        return m;
    endfunction

    // what a result read returns: the fresh outcome in the cycle it is being stored
    function automatic logic [DATA_W-1:0] live_word(input logic              fresh,
                                                    input logic [DATA_W-1:0] calc,
                                                    input logic [DATA_W-1:0] held);
        logic [DATA_W-1:0] w;
        w = held;
        if (fresh) begin
            w = calc;
        end
        return w;
    endfunction

    // control state
    mode_t             mode_r;
    mode_t             mode_nxt;
    logic              start_r;
    logic              start_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // operand and result state, no reset: operands survive reset, results undefined
    logic [DATA_W-1:0] first_operand_r;
    logic [DATA_W-1:0] first_operand_nxt;
    logic [DATA_W-1:0] second_operand_r;
    logic [DATA_W-1:0] second_operand_nxt;
    logic [DATA_W-1:0] result_low_word_r;
    logic [DATA_W-1:0] result_low_word_nxt;
    logic [DATA_W-1:0] result_high_word_r;
    logic [DATA_W-1:0] result_high_word_nxt;
    logic [DATA_W-1:0] sum_extension_r;
    logic [DATA_W-1:0] sum_extension_nxt;

    reg_sel_t          wsel;
    reg_sel_t          rsel;
    logic [DATA_W-1:0] wvalue;
    logic [DATA_W-1:0] calc_lo;
    logic [DATA_W-1:0] calc_hi;
    logic [DATA_W-1:0] calc_ext;
    logic [DATA_W-1:0] live_lo;
    logic [DATA_W-1:0] live_hi;
    logic [DATA_W-1:0] live_ext;

    hm_arith #(
        .W      (DATA_W)
    ) u_arith (
        .i_mode (mode_r),
        .i_a    (first_operand_r),
        .i_b    (second_operand_r),
        .i_acc  ({result_high_word_r, result_low_word_r}),
        .o_lo   (calc_lo),
        .o_hi   (calc_hi),
        .o_ext  (calc_ext)
    );

    assign wsel = i_wr ? decode(i_addr) : sel_none;
    assign rsel = decode(i_addr);
    // byte writes clear the high byte so 8-bit operands need no masking
    assign wvalue = i_byte ? {{(DATA_W-`HM_BYTE_W){1'b0}}, i_wdata[`HM_BYTE_W-1:0]}
                           : i_wdata;

    // forwarding lets the very next access read the new outcome; without it a read
    // right after the trigger would still return the previous result
    always_comb begin
        live_lo  = live_word(start_r, calc_lo, result_low_word_r);
        live_hi  = live_word(start_r, calc_hi, result_high_word_r);
        live_ext = live_word(start_r, calc_ext, sum_extension_r);
    end

    // control next state
    always_comb begin
        mode_nxt  = mode_r;
        start_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (wsel == sel_first_operand) begin
            mode_nxt = alias_mode(i_addr);
        end
        if (wsel == sel_second_operand) begin
            start_nxt = 1'b1;
        end
        // unmapped reads return zero rather than a stale word
        if (i_rd) begin
            unique case (rsel)
                sel_first_operand:    rdata_nxt = first_operand_r;
                sel_second_operand:   rdata_nxt = second_operand_r;
                sel_result_low_word:  rdata_nxt = live_lo;
                sel_result_high_word: rdata_nxt = live_hi;
                sel_sum_extension:    rdata_nxt = live_ext;
                sel_none:             rdata_nxt = DATA_W'(`HM_RDATA_RST);
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            mode_r  <= unsigned_multiply_mode;
            start_r <= 1'b0;
            rdata_r <= DATA_W'(`HM_RDATA_RST);
        end else begin
            mode_r  <= mode_nxt;
            start_r <= start_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // datapath next state
    always_comb begin
        first_operand_nxt    = first_operand_r;
        second_operand_nxt   = second_operand_r;
        result_low_word_nxt  = result_low_word_r;
        result_high_word_nxt = result_high_word_r;
        sum_extension_nxt    = sum_extension_r;
        if (wsel == sel_first_operand) begin
            first_operand_nxt = wvalue;
        end
        if (wsel == sel_second_operand) begin
            second_operand_nxt = wvalue;
        end
        if (wsel == sel_result_low_word) begin
            result_low_word_nxt = wvalue;
        end
        if (wsel == sel_result_high_word) begin
            result_high_word_nxt = wvalue;
        end
        // sum extension ignores writes; the running operation wins over any
        // result write landing in the same cycle
        if (start_r) begin
            result_low_word_nxt  = calc_lo;
            result_high_word_nxt = calc_hi;
            sum_extension_nxt    = calc_ext;
        end
    end

    // operands keep their value through reset, so this bank has no reset branch
    always_ff @(posedge i_mclk) begin
        first_operand_r    <= first_operand_nxt;
        second_operand_r   <= second_operand_nxt;
        result_low_word_r  <= result_low_word_nxt;
        result_high_word_r <= result_high_word_nxt;
        sum_extension_r    <= sum_extension_nxt;
    end

    assign o_rdata = rdata_r;
    // low only in the cycle between trigger capture and result update
    assign o_result_ready = ~start_r;

endmodule // peripheral_multiply_accumulate

//--- testbench/cpu_bus_model.sv
// behavioural cpu issuing single-cycle word and byte accesses
// assumes every task is entered at a falling clock edge
`timescale 1ns/1ps
module cpu_bus_model (
    // clock
    input  wire logic        i_mclk,
    // bus towards the peripheral
    output logic      [15:0] o_addr = 16'h0000,
    output logic      [15:0] o_wdata = 16'h0000,
    output logic             o_wr = 1'b0,
    output logic             o_rd = 1'b0,
    output logic             o_byte = 1'b0,
    input  wire logic [15:0] i_rdata
);
    // one access at a time, so nothing slips between operand writes
    task automatic cycle(input logic w, input logic r, input logic b, input logic [15:0] a,
                         input logic [15:0] d);
        o_wr = w;
        o_rd = r;
        o_byte = b;
        o_addr = a;
        o_wdata = d;
        @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d, input logic b);
        cycle(1'b1, 1'b0, b, a, d);
    endtask
    // a read is always its own cycle after a trigger
    task automatic bus_rd(input logic [15:0] a, output logic [15:0] q);
        cycle(1'b0, 1'b1, 1'b0, a, ~o_wdata);
        q = i_rdata;
    endtask
endmodule // cpu_bus_model

//--- testbench/peripheral_multiply_accumulate_asserts.sv
// port checker for the multiply-accumulate peripheral
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`include "hm_params.svh"
module peripheral_multiply_accumulate_asserts
    import hm_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic              i_mclk,
    input wire logic              i_rstn,
    // watched bus
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic              i_byte,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_result_ready
);
    logic trig;
    assign trig = i_wr && (i_addr == `HM_OFS_OPERAND_B);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    property p_ready_drop; trig |=> !o_result_ready; endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high");
    property p_ready_back; $fell(o_result_ready) && !trig |=> o_result_ready; endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready low too long");
    property p_ready_cause; !o_result_ready |-> $past(trig); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready low, no trigger");
    property p_hold; !i_rd |=> $stable(o_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_unmapped; i_rd && (i_addr < 16'h0130 || i_addr > 16'h013e) |=> o_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mul_ext; (i_wr && i_addr == `HM_OFS_UNS_MUL_A) ##1 trig
        ##1 (i_rd && i_addr == `HM_OFS_SUM_EXT) |=> o_rdata == 16'h0000; endproperty
    a_mul_ext: assert property (p_mul_ext) else $error("unsigned multiply ext not zero");
    property p_op_keep; (i_wr && i_addr == `HM_OFS_UNS_MUL_A) ##1 (i_rd && i_addr ==
        `HM_OFS_UNS_MUL_A) |=> o_rdata == ($past(i_wdata, 2) & ($past(i_byte, 2) ? 16'h00ff
        : 16'hffff)); endproperty
    a_op_keep: assert property (p_op_keep) else $error("first operand not kept");
    property p_lo_wr; !trig ##1 (i_wr && i_addr == `HM_OFS_RESULT_LO) ##1 (i_rd && i_addr ==
        `HM_OFS_RESULT_LO) |=> o_rdata == $past(i_wdata, 2); endproperty
    a_lo_wr: assert property (p_lo_wr) else $error("low result word not writable");
endmodule // peripheral_multiply_accumulate_asserts

bind peripheral_multiply_accumulate peripheral_multiply_accumulate_asserts #(
    .DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_byte(i_byte),
    .o_rdata(o_rdata), .o_result_ready(o_result_ready));

//--- testbench/peripheral_multiply_accumulate_tb_top.sv
// self-checking bench: cpu model drives every mode and register
// assumes the checker is bound to the design
`timescale 1ns/1ps
`include "hm_params.svh"
module peripheral_multiply_accumulate_tb_top;
    import hm_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rstn = 1'b0;
    logic [15:0] addr, wdata, rdata, q;
    logic        wr, rd, bsel, ready;
    logic [31:0] acc;
    logic [47:0] want;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [15:0] alias_a [4] = '{`HM_OFS_UNS_MUL_A, `HM_OFS_SGN_MUL_A, `HM_OFS_UNS_ACC_A,
                                 `HM_OFS_SGN_ACC_A};

    always #5 i_mclk = ~i_mclk;
    cpu_bus_model cpu (.i_mclk(i_mclk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
                       .o_rd(rd), .o_byte(bsel), .i_rdata(rdata));
    peripheral_multiply_accumulate dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_byte(bsel), .o_rdata(rdata),
        .o_result_ready(ready));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles > 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [47:0] model(input int m, input logic [15:0] a,
                                          input logic [15:0] b, input logic [31:0] s);
        logic [31:0] pu;
        logic [31:0] ps;
        logic [32:0] t;
        pu = {16'h0000, a} * {16'h0000, b};
        ps = {{16{a[15]}}, a} * {{16{b[15]}}, b};
        case (m)
            0: return {16'h0000, pu};
            1: return {{16{ps[31]}}, ps};
            2: t = {1'b0, s} + {1'b0, pu};
            default: t = {s[31], s} + {ps[31], ps};
        endcase
        return (m == 2) ? {15'h0000, t[32], t[31:0]} : {{16{t[32]}}, t[31:0]};
    endfunction
    task automatic run_op(input int m, input logic [15:0] a, input logic [15:0] b,
                          input logic [31:0] pre, input bit load_a);
        if (load_a) begin
            cpu.bus_wr(`HM_OFS_RESULT_LO, pre[15:0], 1'b0);
            cpu.bus_wr(`HM_OFS_RESULT_HI, pre[31:16], 1'b0);
            cpu.bus_wr(alias_a[m], a, 1'b0);
            acc = pre;
        end
        cpu.bus_wr(`HM_OFS_OPERAND_B, b, 1'b0);
        want = model(m, a, b, acc);
        check({15'h0000, ready}, 16'h0000);
        cpu.bus_rd(`HM_OFS_SUM_EXT, q);
        check(q, want[47:32]);
        cpu.bus_rd(`HM_OFS_RESULT_LO, q);
        check(q, want[15:0]);
        cpu.bus_rd(`HM_OFS_RESULT_HI, q);
        check(q, want[31:16]);
        acc = want[31:0];
        $display("op in mode %0d done", m);
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rstn = 1'b1;
        cpu.bus_rd(16'h0140, q);
        check(q, `HM_RDATA_RST);
        $display("unmapped read test done");
        run_op(0, 16'h1234, 16'h5678, 32'h00000000, 1'b1);
        run_op(1, 16'hffff, 16'h0002, 32'h00000000, 1'b1);
        // carry out of the 32-bit sum
        run_op(2, 16'h0001, 16'h0002, 32'hffffffff, 1'b1);
        // signed wrap: true sign stays negative
        run_op(3, 16'hffff, 16'h0001, 32'h80000000, 1'b1);
        run_op(3, 16'hffff, 16'h0003, 32'h00000000, 1'b0);
        cpu.bus_wr(`HM_OFS_SUM_EXT, 16'h1234, 1'b0);
        cpu.bus_rd(`HM_OFS_SUM_EXT, q);
        check(q, 16'h0000);
        cpu.bus_wr(`HM_OFS_RESULT_LO, 16'ha5c3, 1'b0);
        cpu.bus_rd(`HM_OFS_RESULT_LO, q);
        check(q, 16'ha5c3);
        cpu.bus_wr(`HM_OFS_UNS_MUL_A, 16'h9abc, 1'b1);
        cpu.bus_rd(`HM_OFS_UNS_MUL_A, q);
        check(q, 16'h00bc);
        $display("register access test done");
        tally_and_finish();
    end
endmodule // peripheral_multiply_accumulate_tb_top
